// file: bench/stage_cfg_bank_tb.sv
// Self-checking testbench for the per-stage configuration bank
`timescale 1ns/1ps
`default_nettype none
module stage_cfg_bank_tb;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] address = 8'h00;
    logic [15:0] write_data = 16'h0000;
    logic write_strobe = 1'b0;
    logic read_strobe = 1'b0;
    logic [2:0] active_stage = 3'h0;
    logic [15:0] read_data;
    logic [1:0] input7_route_sel;
    logic [1:0] single_ended_route_sel;
    logic input7_to_neg, input7_to_pos, input7_to_bias, mode_invalid;
    logic neg_offset_on, pos_offset_on;
    logic [5:0] neg_offset_amount, pos_offset_amount;
    logic [5:0] offset_to_pos_input, offset_to_neg_input;
    logic [3:0] neg_thresh_sens, pos_thresh_sens;
    logic [2:0] neg_peak_level, pos_peak_level;
    int n_mismatch = 0;
    int check_count = 0;

    always #50 clock = ~clock;

    stage_cfg_bank stage_cfg_bank_inst (
        .clock(clock), .rstn(rstn), .address(address),
        .write_data(write_data), .write_strobe(write_strobe),
        .read_strobe(read_strobe), .read_data(read_data),
        .active_stage(active_stage), .input7_route_sel(input7_route_sel),
        .input7_to_neg(input7_to_neg), .input7_to_pos(input7_to_pos),
        .input7_to_bias(input7_to_bias),
        .single_ended_route_sel(single_ended_route_sel),
        .mode_invalid(mode_invalid), .neg_offset_on(neg_offset_on),
        .pos_offset_on(pos_offset_on), .neg_offset_amount(neg_offset_amount),
        .pos_offset_amount(pos_offset_amount),
        .offset_to_pos_input(offset_to_pos_input),
        .offset_to_neg_input(offset_to_neg_input),
        .neg_thresh_sens(neg_thresh_sens), .pos_thresh_sens(pos_thresh_sens),
        .neg_peak_level(neg_peak_level), .pos_peak_level(pos_peak_level)
    );

    // ------------------------------------------------------------
    // Patterns, checks and bus cycles
    // ------------------------------------------------------------
    function automatic logic [7:0] reg_addr(input int s, input int r);
        return stage_cfg_pkg::stage_base + stage_cfg_pkg::stage_stride * 8'(s)
            + 8'(r);
    endfunction
    // Spare bits kept zero, offset enables left on
    function automatic logic [15:0] route_word(input int s);
        return {2'h0, 2'(s + 1), 10'h000, 2'(s)};
    endfunction
    function automatic logic [15:0] offset_word(input int s);
        logic [2:0] t;
        t = 3'(s);
        return {t[0], t[2], 6'(7 * s + 33), t[0], t[1], 6'(5 * s + 2)};
    endfunction
    function automatic logic [15:0] sens_word(input int s);
        logic [2:0] t;
        t = 3'(s);
        return {t[0], 3'(7 - s), 4'(15 - s), t[1], 3'(s), 4'(s)};
    endfunction
    function automatic logic [2:0] clamp(input logic [2:0] p);
        return (p > 3'h5) ? 3'h5 : p;
    endfunction
    // Expected {to positive, to negative}: bit 2 swaps, bits 1:0 disable
    function automatic logic [11:0] steer_exp(input int b);
        logic [5:0] p;
        logic [5:0] n;
        p = (!b[0] && b[2]) ? 6'h15 : 6'h00;
        p = p | ((!b[1] && !b[2]) ? 6'h2a : 6'h00);
        n = (!b[0] && !b[2]) ? 6'h15 : 6'h00;
        n = n | ((!b[1] && b[2]) ? 6'h2a : 6'h00);
        return {p, n};
    endfunction

    task automatic stop_test();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check_read(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_out(input logic [15:0] got, input logic [15:0] exp,
                             input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s is %h expected %h", $time, what, got,
                     exp);
        end
    endtask
    task automatic cycle_end();
        @(posedge clock);
        #1;
    endtask
    task automatic idle(input int n);
        write_strobe <= 1'b0;
        read_strobe <= 1'b0;
        repeat (n) cycle_end();
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        read_strobe <= 1'b0;
        cycle_end();
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        address <= a;
        read_strobe <= 1'b1;
        write_strobe <= 1'b0;
        cycle_end();
        check_read(read_data, exp);
    endtask
    task automatic check_stage(input int s);
        logic [15:0] r, o, e;
        r = route_word(s);
        o = offset_word(s);
        e = sens_word(s);
        check_out(16'(input7_route_sel), 16'(r[1:0]), "route");
        check_out(16'({input7_to_neg, input7_to_pos, input7_to_bias}),
            16'({r[1:0] == 2'h1, r[1:0] == 2'h2, r[1:0] == 2'h3}),
            "dec");
        check_out(16'({single_ended_route_sel, mode_invalid}),
            16'({r[13:12], r[13:12] == 2'h0}), "mode");
        check_out(16'({neg_offset_amount, pos_offset_amount}),
            16'({o[5:0], o[13:8]}), "amount");
        check_out(16'({offset_to_pos_input, offset_to_neg_input}),
            o[7] ? 16'({o[5:0], o[13:8]}) : 16'({o[13:8], o[5:0]}),
            "steer");
        check_out(16'({neg_thresh_sens, pos_thresh_sens}),
            16'({e[3:0], e[11:8]}), "sens");
        check_out(16'({neg_peak_level, pos_peak_level}),
            16'({clamp(e[6:4]), clamp(e[14:12])}), "peak");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clock);
        #1;
        rstn <= 1'b1;
        for (int a = 0; a < 32; a++) rd(8'(a), 16'h0000);
        idle(1);
        check_out(read_data, 16'h0000, "idle read data");
        check_out(16'({mode_invalid, neg_offset_on, pos_offset_on}),
            16'h0007, "reset decode");
        for (int s = 0; s < 8; s++) begin
            wr(reg_addr(s, 0), route_word(s));
            wr(reg_addr(s, 1), offset_word(s));
            wr(reg_addr(s, 2), sens_word(s));
            wr(reg_addr(s, 3), 16'hffff);
        end
        wr(8'h20, 16'hffff);
        wr(8'hff, 16'h1234);
        for (int s = 0; s < 8; s++) begin
            rd(reg_addr(s, 0), route_word(s));
            rd(reg_addr(s, 1), offset_word(s));
            rd(reg_addr(s, 2), sens_word(s));
            rd(reg_addr(s, 3), 16'h0000);
        end
        rd(8'h20, 16'h0000);
        rd(8'hff, 16'h0000);
        for (int s = 0; s < 8; s++) begin
            active_stage <= 3'(s);
            idle(2);
            check_stage(s);
        end
        // Read straight after write, neighbour untouched
        wr(reg_addr(3, 2), 16'h5a5a);
        rd(reg_addr(3, 2), 16'h5a5a);
        rd(reg_addr(2, 2), sens_word(2));
        active_stage <= 3'h0;
        for (int b = 0; b < 8; b++) begin
            wr(reg_addr(0, 0), {2'(b), 14'h0000});
            wr(reg_addr(0, 1), b[2] ? 16'haa95 : 16'h2a15);
            idle(2);
            check_out(16'({neg_offset_on, pos_offset_on}),
                16'({b[0] == 1'b0, b[1] == 1'b0}), "offset on");
            check_out(16'({offset_to_pos_input, offset_to_neg_input}),
                16'(steer_exp(b)), "gated steer");
        end
        rstn <= 1'b0;
        idle(1);
        rstn <= 1'b1;
        rd(reg_addr(5, 1), 16'h0000);
        stop_test();
    end
endmodule
`default_nettype wire

// file: include/stage_cfg_pkg.sv
// Register layout and field constants for the per-stage configuration bank
package stage_cfg_pkg;
    localparam int num_stages = 8;
    localparam int addr_width = 8;
    localparam int data_width = 16;
    // Word index of each stage's block and the three registers within it
    localparam logic [7:0] stage_base = 8'h00;
    localparam logic [7:0] stage_stride = 8'h04;
    localparam logic [1:0] off_input7_route = 2'h0;
    localparam logic [1:0] off_frontend_offset = 2'h1;
    localparam logic [1:0] off_thresh_sens = 2'h2;
    localparam logic [15:0] reset_value = 16'h0000;
    // Input-7 setup fields
    localparam int route_lsb = 0;
    localparam int se_lsb = 12;
    localparam int neg_off_bit = 14;
    localparam int pos_off_bit = 15;
    localparam logic [15:0] route_spare_mask = 16'h0ffc;
    // Offset fields
    localparam int neg_amt_lsb = 0;
    localparam int neg_swap_bit = 7;
    localparam int pos_amt_lsb = 8;
    localparam int pos_swap_bit = 15;
    // Sensitivity fields
    localparam int neg_sens_lsb = 0;
    localparam int neg_peak_lsb = 4;
    localparam int pos_sens_lsb = 8;
    localparam int pos_peak_lsb = 12;
    localparam logic [2:0] peak_max_code = 3'h5;
    // Route codes for sense input 7
    localparam logic [1:0] route_open = 2'h0;
    localparam logic [1:0] route_neg = 2'h1;
    localparam logic [1:0] route_pos = 2'h2;
    localparam logic [1:0] route_bias = 2'h3;
    // Measurement type codes
    localparam logic [1:0] se_invalid = 2'h0;
    localparam logic [1:0] se_pos = 2'h1;
    localparam logic [1:0] se_neg = 2'h2;
    localparam logic [1:0] se_diff = 2'h3;
endpackage

// file: rtl/stage_cfg_bank.sv
// Per-stage configuration bank with decoded front-end controls
// Operation
// - Input 7 route code: open, negative, positive or bias per stage.
// - Bits 13:12 select single-ended or differential type; code 00 invalid.
// - Bit 14 high disables the negative front-end offset.
// - Bit 15 high disables the positive front-end offset.
// - Bits 5:0 set the negative offset amount, 0.32 pF per count.
// - Bits 13:8 set the positive offset amount, 0.32 pF per count.
// - Bit 7 moves the negative offset to the positive input.
// - Bit 15 moves the positive offset to the negative input.
// - Bits 3:0 select one of sixteen negative threshold percentages.
// - Bits 11:8 select the positive threshold with the same table.
// - Bits 6:4 select the negative peak level, 40 to 90 percent.
// - Bits 14:12 select the positive peak level, same table.
// - Each of eight stages holds its own three registers.
`timescale 1ns/1ps
`default_nettype none
module stage_cfg_bank (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] address,
    input wire logic [15:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [15:0] read_data,
    input wire logic [2:0] active_stage,
    output logic [1:0] input7_route_sel,
    output logic input7_to_neg,
    output logic input7_to_pos,
    output logic input7_to_bias,
    output logic [1:0] single_ended_route_sel,
    output logic mode_invalid,
    output logic neg_offset_on,
    output logic pos_offset_on,
    output logic [5:0] neg_offset_amount,
    output logic [5:0] pos_offset_amount,
    output logic [5:0] offset_to_pos_input,
    output logic [5:0] offset_to_neg_input,
    output logic [3:0] neg_thresh_sens,
    output logic [3:0] pos_thresh_sens,
    output logic [2:0] neg_peak_level,
    output logic [2:0] pos_peak_level
);
    // ------------------------------------------------------------
    // Register storage and bus access
    // ------------------------------------------------------------
    logic [15:0] route_reg [stage_cfg_pkg::num_stages];
    logic [15:0] offset_reg [stage_cfg_pkg::num_stages];
    logic [15:0] sens_reg [stage_cfg_pkg::num_stages];
    logic [15:0] next_route_reg [stage_cfg_pkg::num_stages];
    logic [15:0] next_offset_reg [stage_cfg_pkg::num_stages];
    logic [15:0] next_sens_reg [stage_cfg_pkg::num_stages];
    logic [15:0] next_read_data;
    logic [7:0] rel_addr;
    logic [2:0] sel_stage;
    logic [1:0] sel_reg;
    logic in_range;

    assign rel_addr = address - stage_cfg_pkg::stage_base;
    assign sel_stage = rel_addr[4:2];
    assign sel_reg = rel_addr[1:0];
    assign in_range = (rel_addr[7:5] == 3'h0) && (sel_reg != 2'h3);

    // Per-stage copies written by address
    // independent stage copies
    always_comb begin
        for (int i = 0; i < stage_cfg_pkg::num_stages; i++) begin
            next_route_reg[i] = route_reg[i];
            next_offset_reg[i] = offset_reg[i];
            next_sens_reg[i] = sens_reg[i];
        end
        if (write_strobe && in_range) begin
            case (sel_reg)
                stage_cfg_pkg::off_input7_route: begin
                    next_route_reg[sel_stage] = write_data;
                end
                stage_cfg_pkg::off_frontend_offset: begin
                    next_offset_reg[sel_stage] = write_data;
                end
                stage_cfg_pkg::off_thresh_sens: begin
                    next_sens_reg[sel_stage] = write_data;
                end
                default: begin
                end
            endcase
        end
    end

    // Read data, all bits as written; unmapped reads zero
    // spare bits read back
    always_comb begin
        next_read_data = 16'h0000;
        if (read_strobe && in_range) begin
            case (sel_reg)
                stage_cfg_pkg::off_input7_route: begin
                    next_read_data = route_reg[sel_stage];
                end
                stage_cfg_pkg::off_frontend_offset: begin
                    next_read_data = offset_reg[sel_stage];
                end
                stage_cfg_pkg::off_thresh_sens: begin
                    next_read_data = sens_reg[sel_stage];
                end
                default: begin
                    next_read_data = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < stage_cfg_pkg::num_stages; i++) begin
                route_reg[i] <= stage_cfg_pkg::reset_value;
                offset_reg[i] <= stage_cfg_pkg::reset_value;
                sens_reg[i] <= stage_cfg_pkg::reset_value;
            end
            read_data <= 16'h0000;
        end else begin
            for (int i = 0; i < stage_cfg_pkg::num_stages; i++) begin
                route_reg[i] <= next_route_reg[i];
                offset_reg[i] <= next_offset_reg[i];
                sens_reg[i] <= next_sens_reg[i];
            end
            read_data <= next_read_data;
        end
    end

    // ------------------------------------------------------------
    // Field decode for the active stage
    // ------------------------------------------------------------
    logic [15:0] cur_route;
    logic [15:0] cur_offset;
    logic [15:0] cur_sens;
    logic [1:0] next_route_sel;
    logic [1:0] next_se_sel;
    logic next_neg_on;
    logic next_pos_on;
    logic [5:0] next_neg_amt;
    logic [5:0] next_pos_amt;
    logic [5:0] next_to_pos;
    logic [5:0] next_to_neg;
    logic [3:0] next_neg_sens;
    logic [3:0] next_pos_sens;
    logic [2:0] next_neg_peak;
    logic [2:0] next_pos_peak;
    logic [2:0] raw_neg_peak;
    logic [2:0] raw_pos_peak;

    assign cur_route = route_reg[active_stage];
    assign cur_offset = offset_reg[active_stage];
    assign cur_sens = sens_reg[active_stage];

    always_comb begin
        next_route_sel = cur_route[stage_cfg_pkg::route_lsb +: 2];
        next_se_sel = cur_route[stage_cfg_pkg::se_lsb +: 2];
        next_neg_on = !cur_route[stage_cfg_pkg::neg_off_bit];
        next_pos_on = !cur_route[stage_cfg_pkg::pos_off_bit];
        next_neg_amt = cur_offset[stage_cfg_pkg::neg_amt_lsb +: 6];
        next_pos_amt = cur_offset[stage_cfg_pkg::pos_amt_lsb +: 6];
        next_to_pos = 6'h00;
        next_to_neg = 6'h00;
        if (next_neg_on) begin
            if (cur_offset[stage_cfg_pkg::neg_swap_bit]) begin
                next_to_pos = next_neg_amt;
            end else begin
                next_to_neg = next_neg_amt;
            end
        end
        if (next_pos_on) begin
            if (cur_offset[stage_cfg_pkg::pos_swap_bit]) begin
                next_to_neg = next_to_neg | next_pos_amt;
            end else begin
                next_to_pos = next_to_pos | next_pos_amt;
            end
        end
        next_neg_sens = cur_sens[stage_cfg_pkg::neg_sens_lsb +: 4];
        next_pos_sens = cur_sens[stage_cfg_pkg::pos_sens_lsb +: 4];
        raw_neg_peak = cur_sens[stage_cfg_pkg::neg_peak_lsb +: 3];
        raw_pos_peak = cur_sens[stage_cfg_pkg::pos_peak_lsb +: 3];
        next_neg_peak = (raw_neg_peak > stage_cfg_pkg::peak_max_code) ?
            stage_cfg_pkg::peak_max_code : raw_neg_peak;
        next_pos_peak = (raw_pos_peak > stage_cfg_pkg::peak_max_code) ?
            stage_cfg_pkg::peak_max_code : raw_pos_peak;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            input7_route_sel <= stage_cfg_pkg::route_open;
            single_ended_route_sel <= stage_cfg_pkg::se_invalid;
            neg_offset_on <= 1'b0;
            pos_offset_on <= 1'b0;
            neg_offset_amount <= 6'h00;
            pos_offset_amount <= 6'h00;
            offset_to_pos_input <= 6'h00;
            offset_to_neg_input <= 6'h00;
            neg_thresh_sens <= 4'h0;
            pos_thresh_sens <= 4'h0;
            neg_peak_level <= 3'h0;
            pos_peak_level <= 3'h0;
        end else begin
            input7_route_sel <= next_route_sel;
            single_ended_route_sel <= next_se_sel;
            neg_offset_on <= next_neg_on;
            pos_offset_on <= next_pos_on;
            neg_offset_amount <= next_neg_amt;
            pos_offset_amount <= next_pos_amt;
            offset_to_pos_input <= next_to_pos;
            offset_to_neg_input <= next_to_neg;
            neg_thresh_sens <= next_neg_sens;
            pos_thresh_sens <= next_pos_sens;
            neg_peak_level <= next_neg_peak;
            pos_peak_level <= next_pos_peak;
        end
    end

    // Route strobes derived from the registered code
    // route decode
    assign input7_to_neg = (input7_route_sel == stage_cfg_pkg::route_neg);
    assign input7_to_pos = (input7_route_sel == stage_cfg_pkg::route_pos);
    assign input7_to_bias = (input7_route_sel == stage_cfg_pkg::route_bias);
    assign mode_invalid =
        (single_ended_route_sel == stage_cfg_pkg::se_invalid);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_READBACK: assert property (
        @(posedge clock) disable iff (!rstn)
        (write_strobe && in_range) ##1 (read_strobe &&
            address == $past(address)) |=> read_data == $past(write_data, 2))
        else $error("read after write mismatch");
    AST_UNMAPPED: assert property (
        @(posedge clock) disable iff (!rstn)
        (read_strobe && !in_range) |=> read_data == 16'h0000)
        else $error("unmapped read not zero");
    AST_ROUTE: assert property (
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> input7_route_sel == $past(cur_route[1:0]))
        else $error("route code not followed");
    AST_MODE: assert property (
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> mode_invalid == ($past(cur_route[13:12]) == 2'h0))
        else $error("mode invalid flag wrong");
    AST_NEG_OFF: assert property (
        @(posedge clock) disable iff (!rstn)
        $past(cur_route[14]) |-> !neg_offset_on)
        else $error("negative offset not disabled");
    AST_POS_OFF: assert property (
        @(posedge clock) disable iff (!rstn)
        $past(cur_route[15]) |-> !pos_offset_on)
        else $error("positive offset not disabled");
    AST_NEG_AMT: assert property (
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> neg_offset_amount == $past(cur_offset[5:0]))
        else $error("negative amount wrong");
    AST_POS_AMT: assert property (
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> pos_offset_amount == $past(cur_offset[13:8]))
        else $error("positive amount wrong");
    AST_NEG_SWAP: assert property (
        @(posedge clock) disable iff (!rstn)
        (neg_offset_on && !pos_offset_on && $past(cur_offset[7]))
            |-> offset_to_pos_input == neg_offset_amount)
        else $error("negative swap wrong");
    AST_POS_SWAP: assert property (
        @(posedge clock) disable iff (!rstn)
        (pos_offset_on && !neg_offset_on && $past(cur_offset[15]))
            |-> offset_to_neg_input == pos_offset_amount)
        else $error("positive swap wrong");
    AST_SENS: assert property (
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> neg_thresh_sens == $past(cur_sens[3:0]) &&
            pos_thresh_sens == $past(cur_sens[11:8]))
        else $error("threshold code wrong");
    AST_PEAK: assert property (
        @(posedge clock) disable iff (!rstn)
        neg_peak_level <= 3'h5 && pos_peak_level <= 3'h5)
        else $error("peak level beyond clamp");
    AST_NEG_ON: assert property (
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> neg_offset_on == !$past(cur_route[14]))
        else $error("negative offset enable wrong");
    AST_POS_ON: assert property (
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> pos_offset_on == !$past(cur_route[15]))
        else $error("positive offset enable wrong");
    AST_OFF_GATE: assert property (
        @(posedge clock) disable iff (!rstn)
        (!neg_offset_on && !pos_offset_on) |->
            offset_to_pos_input == 6'h00 && offset_to_neg_input == 6'h00)
        else $error("disabled offsets still steered");
    AST_NEG_DIRECT: assert property (
        @(posedge clock) disable iff (!rstn)
        (neg_offset_on && !pos_offset_on && !$past(cur_offset[7])) |->
            offset_to_neg_input == neg_offset_amount &&
            offset_to_pos_input == 6'h00)
        else $error("negative offset not on negative input");
    AST_POS_DIRECT: assert property (
        @(posedge clock) disable iff (!rstn)
        (pos_offset_on && !neg_offset_on && !$past(cur_offset[15])) |->
            offset_to_pos_input == pos_offset_amount &&
            offset_to_neg_input == 6'h00)
        else $error("positive offset not on positive input");
    AST_NEG_PEAK: assert property (
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> $past(cur_sens[6:4]) > 3'h5 ||
            neg_peak_level == $past(cur_sens[6:4]))
        else $error("negative peak level wrong");
    AST_POS_PEAK: assert property (
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> $past(cur_sens[14:12]) > 3'h5 ||
            pos_peak_level == $past(cur_sens[14:12]))
        else $error("positive peak level wrong");
    AST_POS_SENS: assert property (
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> pos_thresh_sens == $past(cur_sens[11:8]))
        else $error("positive threshold code wrong");
    AST_STAGE_HOLD: assert property (
        @(posedge clock) disable iff (!rstn)
        (write_strobe && in_range && sel_stage != active_stage) ##1
            $stable(active_stage) |-> $stable(cur_route) &&
            $stable(cur_offset) && $stable(cur_sens))
        else $error("write disturbed another stage");
    AST_READ_IDLE: assert property (
        @(posedge clock) disable iff (!rstn)
        !read_strobe |=> read_data == 16'h0000)
        else $error("read data not cleared");
endmodule
`default_nettype wire
